/* File: rtl/dma_cp_pkg.sv */
// constants and carrier types for the dma count, page and group-command block
package dma_cp_pkg;
  localparam int unsigned    NUM_CH     = 8;
  localparam int unsigned    CNT_W      = 16;
  localparam int unsigned    PAGE_W     = 8;
  localparam int unsigned    XADDR_W    = 24;
  // count port per channel, index 7 first; channel 4 has none here
  localparam logic [7:0][7:0] CNT_ADDR  = {8'hCE, 8'hCA, 8'hC6, 8'h00, 8'h07, 8'h05, 8'h03, 8'h01};
  localparam logic [7:0][7:0] PAGE_ADDR = {8'h8A, 8'h89, 8'h8B, 8'h00, 8'h82, 8'h81, 8'h83, 8'h87};
  localparam logic [7:0]     CH_PRESENT = 8'hEF;
  localparam logic [7:0]     WORD_CHANS = 8'hE0;
  localparam logic [7:0]     CMD_LOW    = 8'h08;
  localparam logic [7:0]     CMD_HIGH   = 8'hD0;
  localparam int unsigned    CMD_ROT    = 4;
  localparam int unsigned    CMD_DIS    = 2;
  localparam int unsigned    CASCADE_CH = 4;
  localparam logic [15:0]    CNT_WRAP   = 16'hFFFF;
  localparam logic [15:0]    CNT_RST    = 16'h0000;
  localparam logic [7:0]     PAGE_RST   = 8'h00;
  localparam logic [7:0]     UNMAP_DATA = 8'h00;
  localparam logic [1:0]     CMD_RST    = 2'h0;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } io_req_t;
endpackage

/* File: rtl/dma_count_page.sv */
// count, page, group command and status logic of a two-group eight-channel dma controller
module dma_count_page (
  input  wire logic                    CLK_SYS,
  input  wire logic                    RESET_N,
  input  wire dma_cp_pkg::io_req_t     IO_REQ,
  input  wire logic                    IO_REQ_VALID,
  output logic                         IO_REQ_READY,
  output logic [7:0]                   RD_DATA,
  output logic                         RD_VALID,
  input  wire logic                    RD_READY,
  input  wire logic [7:0]              XFER_DONE,
  input  wire logic [7:0]              AUTO_INIT,
  input  wire logic [1:0]              BPTR_CLR,
  input  wire logic [7:0]              REQ_PENDING,
  input  wire logic [7:0][15:0]        CUR_ADDR,
  output logic [7:0][23:0]             XFER_ADDR,
  output logic [7:0]                   TC_PULSE,
  output logic [7:0]                   COUNT_IN_WORDS,
  output logic [1:0]                   GROUP_EN,
  output logic [1:0]                   ROTATE_PRIO
);
  import dma_cp_pkg::*;

  logic                 acc;
  logic                 wr_acc;
  logic                 rd_acc;
  wire  [7:0]           cnt_hit;
  wire  [7:0]           page_hit;
  wire  [7:0]           tc_now;
  wire  [7:0][15:0]     cur_all;
  wire  [7:0][15:0]     base_all;
  logic [1:0]           bptr_ff;
  logic [1:0]           nxt_bptr;
  logic [7:0][7:0]      page_ff;
  logic [7:0][7:0]      nxt_page;
  logic [7:0]           tc_sts_ff;
  logic [7:0]           nxt_tc_sts;
  logic [1:0]           dis_ff;
  logic [1:0]           nxt_dis;
  logic [1:0]           rot_ff;
  logic [1:0]           nxt_rot;
  logic [1:0]           grp_en_ff;
  logic [1:0]           nxt_grp_en;
  logic [7:0]           rd_val;
  logic                 v0_ff;
  logic                 v1_ff;
  logic [7:0]           d0_ff;
  logic [7:0]           d1_ff;
  logic                 nxt_v0;
  logic                 nxt_v1;
  logic [7:0]           nxt_d0;
  logic [7:0]           nxt_d1;
  logic                 rdy_ff;
  logic                 nxt_rdy;
  logic                 pop;
  logic [7:0][23:0]     xaddr_ff;
  logic [7:0][23:0]     nxt_xaddr;
  logic [7:0]           tcp_ff;
  logic [7:0]           words_ff;

  // every access waits for room in the read buffer, so reads are never dropped
  always_comb begin
    acc    = IO_REQ_VALID & rdy_ff;
    wr_acc = acc & IO_REQ.wr;
    rd_acc = acc & IO_REQ.rd;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      logic [15:0] base_ff;
      logic [15:0] cur_ff;
      logic [15:0] nxt_base;
      logic [15:0] nxt_cur;
      logic        tc_c;
      logic        hi_byte;
      logic        cnt_wr;

      assign cnt_hit[gi]  = CH_PRESENT[gi] & (IO_REQ.addr == CNT_ADDR[gi]);
      assign page_hit[gi] = CH_PRESENT[gi] & (IO_REQ.addr == PAGE_ADDR[gi]);
      assign cur_all[gi]  = cur_ff;
      assign base_all[gi] = base_ff;
      assign tc_now[gi]   = tc_c;

      always_comb begin
        nxt_base = base_ff;
        nxt_cur  = cur_ff;
        tc_c     = 1'b0;
        hi_byte  = bptr_ff[gi / 4];
        cnt_wr   = wr_acc & cnt_hit[gi];
        if (cnt_wr) begin
          // write beats a transfer in the same cycle
          if (hi_byte) begin
            nxt_base[15:8] = IO_REQ.wdata;
            nxt_cur[15:8]  = IO_REQ.wdata;
          end else begin
            nxt_base[7:0] = IO_REQ.wdata;
            nxt_cur[7:0]  = IO_REQ.wdata;
          end
        end else if (XFER_DONE[gi] & CH_PRESENT[gi]) begin
          nxt_cur = cur_ff - 16'h0001;
          if (cur_ff == CNT_RST) begin
            // terminal only on the step from zero (wrap, or reload under auto-init), so count+1 transfers happen
            tc_c = 1'b1;
            if (AUTO_INIT[gi]) begin
              nxt_cur = base_ff;
            end
          end
        end
      end

      always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
          base_ff <= CNT_RST;
          cur_ff  <= CNT_RST;
        end else begin
          base_ff <= nxt_base;
          cur_ff  <= nxt_cur;
        end
      end

      always_comb begin
        // page held as written; only the current address moves
        if (WORD_CHANS[gi]) begin
          nxt_xaddr[gi] = {page_ff[gi][7:1], CUR_ADDR[gi], 1'b0};
        end else begin
          nxt_xaddr[gi] = {page_ff[gi], CUR_ADDR[gi]};
        end
      end
    end
  endgenerate

  // byte pointers, one per group; an external clear beats a toggle
  always_comb begin
    nxt_bptr = bptr_ff;
    for (int g = 0; g < 2; g++) begin
      if (BPTR_CLR[g]) begin
        nxt_bptr[g] = 1'b0;
      end else if (acc & (IO_REQ.wr | IO_REQ.rd) & (|cnt_hit[g*4 +: 4])) begin
        nxt_bptr[g] = ~bptr_ff[g];
      end
    end
  end

  always_comb begin
    nxt_page = page_ff;
    for (int c = 0; c < NUM_CH; c++) begin
      if (wr_acc & page_hit[c]) begin
        nxt_page[c] = IO_REQ.wdata;
      end
    end
  end

  // command writes; unused command bits are simply not stored
  always_comb begin
    nxt_dis = dis_ff;
    nxt_rot = rot_ff;
    if (wr_acc & (IO_REQ.addr == CMD_LOW)) begin
      nxt_dis[0] = IO_REQ.wdata[CMD_DIS];
      nxt_rot[0] = IO_REQ.wdata[CMD_ROT];
    end
    if (wr_acc & (IO_REQ.addr == CMD_HIGH)) begin
      nxt_dis[1] = IO_REQ.wdata[CMD_DIS];
      nxt_rot[1] = IO_REQ.wdata[CMD_ROT];
    end
    // lower group reaches the bus only through the cascade channel
    nxt_grp_en[0] = ~nxt_dis[0] & ~nxt_dis[1];
    nxt_grp_en[1] = ~nxt_dis[1];
  end

  // terminal status: sticky, cleared by a status read, a new terminal wins
  always_comb begin
    nxt_tc_sts = tc_sts_ff;
    if (rd_acc & (IO_REQ.addr == CMD_LOW)) begin
      nxt_tc_sts[3:0] = 4'h0;
    end
    if (rd_acc & (IO_REQ.addr == CMD_HIGH)) begin
      nxt_tc_sts[7:4] = 4'h0;
    end
    nxt_tc_sts = nxt_tc_sts | tc_now;
  end

  // read data mux
  always_comb begin
    rd_val = UNMAP_DATA;
    for (int c = 0; c < NUM_CH; c++) begin
      if (cnt_hit[c]) begin
        rd_val = bptr_ff[c / 4] ? cur_all[c][15:8] : cur_all[c][7:0];
      end
      if (page_hit[c]) begin
        rd_val = page_ff[c];
      end
    end
    if (IO_REQ.addr == CMD_LOW) begin
      rd_val = {REQ_PENDING[3:0], tc_sts_ff[3:0]};
    end
    if (IO_REQ.addr == CMD_HIGH) begin
      rd_val = {REQ_PENDING[7:5], |REQ_PENDING[3:0], tc_sts_ff[7:4]};
    end
  end

  // two-entry read buffer; a stalled reader holds the port off via ready
  always_comb begin
    pop    = v0_ff & RD_READY;
    nxt_v0 = v0_ff;
    nxt_v1 = v1_ff;
    nxt_d0 = d0_ff;
    nxt_d1 = d1_ff;
    if (pop) begin
      nxt_v0 = v1_ff;
      nxt_d0 = d1_ff;
      nxt_v1 = 1'b0;
    end
    if (rd_acc) begin
      if (!nxt_v0) begin
        nxt_v0 = 1'b1;
        nxt_d0 = rd_val;
      end else begin
        nxt_v1 = 1'b1;
        nxt_d1 = rd_val;
      end
    end
    nxt_rdy = ~nxt_v1;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      bptr_ff   <= 2'h0;
      page_ff   <= {NUM_CH{PAGE_RST}};
      dis_ff    <= CMD_RST;
      rot_ff    <= CMD_RST;
      grp_en_ff <= 2'h3;
      tc_sts_ff <= 8'h00;
      v0_ff     <= 1'b0;
      v1_ff     <= 1'b0;
      d0_ff     <= 8'h00;
      d1_ff     <= 8'h00;
      rdy_ff    <= 1'b1;
      xaddr_ff  <= '0;
      tcp_ff    <= 8'h00;
      words_ff  <= WORD_CHANS;
    end else begin
      bptr_ff   <= nxt_bptr;
      page_ff   <= nxt_page;
      dis_ff    <= nxt_dis;
      rot_ff    <= nxt_rot;
      grp_en_ff <= nxt_grp_en;
      tc_sts_ff <= nxt_tc_sts;
      v0_ff     <= nxt_v0;
      v1_ff     <= nxt_v1;
      d0_ff     <= nxt_d0;
      d1_ff     <= nxt_d1;
      rdy_ff    <= nxt_rdy;
      xaddr_ff  <= nxt_xaddr;
      tcp_ff    <= tc_now;
      words_ff  <= WORD_CHANS;
    end
  end

  assign IO_REQ_READY   = rdy_ff;
  assign RD_DATA        = d0_ff;
  assign RD_VALID       = v0_ff;
  assign XFER_ADDR      = xaddr_ff;
  assign TC_PULSE       = tcp_ff;
  assign COUNT_IN_WORDS = words_ff;
  assign GROUP_EN       = grp_en_ff;
  assign ROTATE_PRIO    = rot_ff;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);

  property p_cnt_write;
    (wr_acc && cnt_hit[0] && !bptr_ff[0]) |=>
      (cur_all[0][7:0] == $past(IO_REQ.wdata)) && (base_all[0][7:0] == $past(IO_REQ.wdata));
  endproperty
  a_cnt_write: assert property (p_cnt_write) else $error("count write did not load both");

  property p_dec;
    (XFER_DONE[1] && !(wr_acc && cnt_hit[1]) && cur_all[1] != 16'h0000) |=>
      (cur_all[1] == $past(cur_all[1]) - 16'h0001) && !TC_PULSE[1];
  endproperty
  a_dec: assert property (p_dec) else $error("count did not step down by one");

  property p_tc;
    (XFER_DONE[1] && !(wr_acc && cnt_hit[1]) && cur_all[1] == 16'h0000 && !AUTO_INIT[1]) |=>
      TC_PULSE[1] && (cur_all[1] == CNT_WRAP) ##1 !TC_PULSE[1];
  endproperty
  a_tc: assert property (p_tc) else $error("terminal count missing on wrap");

  property p_autoinit;
    (XFER_DONE[6] && !(wr_acc && cnt_hit[6]) && cur_all[6] == 16'h0000 && AUTO_INIT[6]) |=>
      (cur_all[6] == $past(base_all[6])) && TC_PULSE[6];
  endproperty
  a_autoinit: assert property (p_autoinit) else $error("auto-init reload failed");

  property p_page;
    ##1 XFER_ADDR[0] == {$past(page_ff[0]), $past(CUR_ADDR[0])};
  endproperty
  a_page: assert property (p_page) else $error("byte channel address wrong");

  property p_word_addr;
    ##1 XFER_ADDR[6] == {$past(page_ff[6][7:1]), $past(CUR_ADDR[6]), 1'b0};
  endproperty
  a_word_addr: assert property (p_word_addr) else $error("word channel address wrong");

  property p_cmd;
    (wr_acc && IO_REQ.addr == CMD_LOW) |=>
      (ROTATE_PRIO[0] == $past(IO_REQ.wdata[4])) && (GROUP_EN[0] == (!$past(IO_REQ.wdata[2]) && !dis_ff[1]));
  endproperty
  a_cmd: assert property (p_cmd) else $error("low group command not applied");

  property p_cascade_dis;
    (wr_acc && IO_REQ.addr == CMD_HIGH && IO_REQ.wdata[2]) |=> !GROUP_EN[0] && !GROUP_EN[1];
  endproperty
  a_cascade_dis: assert property (p_cascade_dis) else $error("upper disable left lower group on");

  property p_req_or;
    (rd_acc && IO_REQ.addr == CMD_HIGH && !v0_ff) |=>
      (RD_DATA[7:4] == {$past(REQ_PENDING[7:5]), |$past(REQ_PENDING[3:0])});
  endproperty
  a_req_or: assert property (p_req_or) else $error("high status request bits wrong");

  property p_tc_sticky;
    tc_now[0] |=> tc_sts_ff[0];
  endproperty
  a_tc_sticky: assert property (p_tc_sticky) else $error("terminal status not set");

  property p_bptr;
    (acc && IO_REQ.rd && cnt_hit[7] && !BPTR_CLR[1]) |=> bptr_ff[1] != $past(bptr_ff[1]);
  endproperty
  a_bptr: assert property (p_bptr) else $error("byte pointer did not toggle");

  property p_full;
    v1_ff |-> !IO_REQ_READY;
  endproperty
  a_full: assert property (p_full) else $error("accepting while buffer full");

  // a stalled reader must see the same answer until it takes it
  property p_rd_hold;
    (RD_VALID && !RD_READY) |=> RD_VALID && $stable(RD_DATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read answer moved while stalled");

  property p_sts_clr;
    (rd_acc && IO_REQ.addr == CMD_HIGH && !(|tc_now[7:4])) |=> tc_sts_ff[7:4] == 4'h0;
  endproperty
  a_sts_clr: assert property (p_sts_clr) else $error("terminal status not cleared by read");

  c_autoinit: cover property (XFER_DONE[6] && cur_all[6] == 16'h0000 && AUTO_INIT[6] ##1 TC_PULSE[6]);
  c_cascade: cover property (wr_acc && IO_REQ.addr == CMD_HIGH && IO_REQ.wdata[CMD_DIS]);
  c_full: cover property (v1_ff ##1 v1_ff);
  c_status: cover property (rd_acc && IO_REQ.addr == CMD_LOW && |tc_sts_ff[3:0]);
endmodule

/* File: sim/dma_peripheral.sv */
// peripheral model: requests transfers on one channel until terminal count
module dma_peripheral (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [2:0] chan,
  input  wire logic [7:0] tc,
  output logic [7:0]      done,
  output logic [7:0]      req,
  output int              n_xfer
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy = 1'b0;
  int   gap  = 0;
  initial begin
    done = 8'h00;
    req = 8'h00;
    n_xfer = 0;
  end
  // gap of one to three cycles, so the terminal pulse lands before another strobe
  always @(posedge clk) begin
    done <= 8'h00;
    if (start) begin
      busy <= 1'b1;
      n_xfer <= 0;
      gap <= 0;
      req[chan] <= 1'b1;
    end else if (busy && tc[chan]) begin
      busy <= 1'b0;
      req <= 8'h00;
    end else if (busy && gap == 0) begin
      done[chan] <= 1'b1;
      n_xfer <= n_xfer + 1;
      gap <= 1 + n_xfer % 3;
    end else if (gap > 0) gap <= gap - 1;
  end
endmodule

/* File: sim/test_dma_count_page.sv */
// self-checking bench for the dma count, page and group-command block
module test_dma_count_page;
  timeunit 1ns;
  timeprecision 1ps;
  import dma_cp_pkg::*;
  logic              clk = 0, rst_n = 0, vld = 0, rdy = 0, stall = 1, start = 0, io_rdy, rd_vld;
  io_req_t           req = '0;
  logic [7:0]        rd_data, done, p_req, tc, words, ai, tbreq, pg [8];
  logic [1:0]        bclr, gen, rot;
  logic [2:0]        chan = 0;
  logic [7:0][15:0]  ca;
  logic [7:0][23:0]  xa;
  logic [15:0]       e, expq[$];
  logic [31:0]       seed = 32'h0000_2096;
  int                n_fail = 0, total_checks = 0, nx;

  initial forever #20 clk = ~clk;
  dma_count_page i_dma_count_page (.CLK_SYS(clk), .RESET_N(rst_n), .IO_REQ(req), .IO_REQ_VALID(vld),
    .IO_REQ_READY(io_rdy), .RD_DATA(rd_data), .RD_VALID(rd_vld), .RD_READY(rdy), .XFER_DONE(done),
    .AUTO_INIT(ai), .BPTR_CLR(bclr), .REQ_PENDING(p_req | tbreq), .CUR_ADDR(ca), .XFER_ADDR(xa),
    .TC_PULSE(tc), .COUNT_IN_WORDS(words), .GROUP_EN(gen), .ROTATE_PRIO(rot));
  dma_peripheral i_dma_peripheral (.clk(clk), .start(start), .chan(chan), .tc(tc), .done(done),
    .req(p_req), .n_xfer(nx));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [23:0] x, s);
    total_checks++;
    if (s !== x) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // request held from a falling edge until a rising edge sees ready
  task automatic io(input logic r, input logic [7:0] a, d);
    req = '{rd: r, wr: !r, addr: a, wdata: d};
    vld = 1;
    while (io_rdy !== 1) @(negedge clk);
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, x, input logic [7:0] m = 8'hFF);
    expq.push_back({m, x & m});
    io(1, a, 8'h00);
  endtask
  task automatic idle(input int n);
    vld = 0;
    repeat (n) @(negedge clk);
  endtask
  task automatic drain();
    for (int k = 0; k < 200 && expq.size() != 0; k++) @(negedge clk);
  endtask
  task automatic bptr(input logic g);
    vld = 0;
    bclr[g] = 1;
    @(negedge clk);
    bclr = 2'h0;
  endtask
  task automatic cnt_wr(input int c, input logic [15:0] v);
    bptr(c > 3);
    io(0, CNT_ADDR[c], v[7:0]);
    io(0, CNT_ADDR[c], v[15:8]);
  endtask
  task automatic cnt_rd(input int c, input logic [15:0] v);
    bptr(c > 3);
    rd(CNT_ADDR[c], v[7:0]);
    rd(CNT_ADDR[c], v[15:8]);
  endtask
  task automatic xfer(input int c, input logic [15:0] n, input logic a, input logic [7:0] q);
    logic [7:0] st, p, m;
    int k;
    ai = a ? 8'h01 << c : 8'h00;
    tbreq = q;
    cnt_wr(c, n);
    idle(1);
    chan = c[2:0];
    start = 1;
    @(negedge clk);
    start = 0;
    for (k = 0; k < 500 && tc[c] !== 1; k++) @(negedge clk);
    chk("n_xfer", 24'(n + 1), 24'(nx));
    idle(3);
    p = c < 4 ? CMD_LOW : CMD_HIGH;
    m = c < 4 ? 8'hFF : 8'hFE;
    st = c < 4 ? {q[3:0], 4'h1 << c} : {q[7:5], |q[3:0], 4'h1 << (c - 4)};
    rd(p, st, m);
    rd(p, st & 8'hF0, m);
    cnt_rd(c, a ? n : CNT_WRAP);
    $display("transfer test done on channel %0d", c);
  endtask

  // reader stalls at random, or fully while the buffer is being filled
  always @(negedge clk) rdy <= stall ? 1'b0 : 1'(rnd());
  always @(posedge clk) if (rd_vld === 1 && rdy === 1) begin
    if (expq.size() == 0) chk("rd_extra", 24'h0, 24'h1);
    else begin
      e = expq.pop_front();
      chk("rd_data", 24'(e[7:0]), 24'(rd_data & e[15:8]));
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done();
  end

  initial begin
    int c;
    int k;
    logic [15:0] v [8];
    static logic [7:0] cp [5] = '{CMD_LOW, CMD_HIGH, CMD_HIGH, CMD_LOW, CMD_LOW};
    static logic [7:0] cd [5] = '{8'h10, 8'h14, 8'h00, 8'h04, 8'h00};
    static logic [1:0] ce [5] = '{2'h3, 2'h0, 2'h3, 2'h2, 2'h3};
    static logic [1:0] cr [5] = '{2'h1, 2'h3, 2'h1, 2'h0, 2'h0};
    ca = '0;
    ai = 0;
    tbreq = 0;
    bclr = 0;
    repeat (3) @(negedge clk);
    rst_n = 1;
    stall = 0;
    chk("group_en", 24'(2'h3), 24'(gen));
    chk("rotate", 24'(2'h0), 24'(rot));
    chk("words", 24'(WORD_CHANS), 24'(words));
    for (c = 0; c < 5; c++) begin
      io(0, cp[c], cd[c]);
      idle(1);
      chk("group_en", 24'(ce[c]), 24'(gen));
      chk("rotate", 24'(cr[c]), 24'(rot));
    end
    $display("command test done");
    for (c = 0; c < 8; c++) if (CH_PRESENT[c]) begin
      v[c] = 16'(rnd());
      cnt_wr(c, v[c]);
    end
    for (c = 0; c < 8; c++) if (CH_PRESENT[c]) cnt_rd(c, v[c]);
    rd(8'h40, UNMAP_DATA);
    rd(8'hC2, UNMAP_DATA);
    $display("count test done");
    for (c = 0; c < 8; c++) if (CH_PRESENT[c]) begin
      pg[c] = 8'(rnd());
      io(0, PAGE_ADDR[c], pg[c]);
    end
    for (k = 0; k < 2; k++) begin
      ca = {rnd(), rnd(), rnd(), rnd()};
      idle(2);
      for (c = 0; c < 8; c++) if (CH_PRESENT[c])
        chk("xfer_addr", WORD_CHANS[c] ? {pg[c][7:1], ca[c], 1'b0} : {pg[c], ca[c]}, xa[c]);
    end
    drain();
    stall = 1;
    idle(2);
    rd(PAGE_ADDR[0], pg[0]);
    rd(PAGE_ADDR[5], pg[5]);
    chk("io_ready", 24'h0, 24'(io_rdy));
    stall = 0;
    rd(PAGE_ADDR[7], pg[7]);
    $display("page test done");
    xfer(1, 16'h0004, 0, 8'h00);
    xfer(6, 16'h0002, 1, 8'h25);
    xfer(0, 16'h0000, 0, 8'hC8);
    xfer(7, 16'h0001, 0, 8'h0A);
    idle(1);
    drain();
    chk("reads_left", 24'h0, 24'(expq.size()));
    test_done();
  end
endmodule
